/* rtl/buffer_slot_status.sv */
/*
 * Slot status bank for all message buffers: per-buffer status words
 * written by the message handler, a per-buffer changed summary, and a
 * plain register port for the host.
 * Assumes update, slot end and rewrite inputs come from logic on mclk_in.
 */
`timescale 1ns/10ps

module buffer_slot_status
	import slot_status_pkg::*;
(
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             rst_b_in,
	// register port
	input  wire logic [7:0]       reg_addr_in,
	input  wire logic [31:0]      reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output logic      [31:0]      reg_rdata_out,
	// message handler
	input  wire logic             upd_valid_in,
	input  wire update_t          upd_in,
	input  wire logic             slot_end_in,
	// input staging buffer
	input  wire logic             rewrite_in,
	input  wire logic [BUF_W-1:0] rewrite_buf_in,
	// summary
	output logic                  any_changed_out
);

	typedef struct packed {
		slot_status_t [NUM_BUF-1:0] stat;
		logic [NUM_BUF-1:0]         changed;
		logic [BUF_W-1:0]           sel;
		update_t                    pend;
		logic                       pend_valid;
		logic [31:0]                rdata;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic                       apply;
	slot_status_t               applied;
	slot_status_t [NUM_BUF-1:0] stat_n;
	logic [NUM_BUF-1:0]         chg_n;
	logic                       host_clear;
	logic                       status_read;

	// merge one slot outcome into the old status word
	function automatic slot_status_t merge(input slot_status_t old, input update_t u);
		slot_status_t s;
		logic         got_a;
		logic         got_b;
		s     = old;
		got_a = u.assign_a & u.chan_a.good_frame;
		got_b = u.assign_b & u.chan_b.good_frame;
		// header indicators keep their value unless a valid frame came in
		if (got_a | got_b)
		begin
			s.rx_reserved_bit       = u.rx_reserved;
			s.rx_preamble_indicator = u.rx_preamble;
			s.rx_nonnull_indicator  = u.rx_nonnull;
			s.rx_sync_indicator     = u.rx_sync;
			s.rx_startup_indicator  = u.rx_startup;
			s.rx_channel_indicator  = got_a;
		end
		s.captured_cycle_count = u.cycle_count;
		if (u.assign_a)
		begin
			s.tx_done_chan_a            = old.tx_done_chan_a | u.chan_a.tx_done;
			s.idle_slot_chan_a          = u.chan_a.idle;
			s.tx_conflict_chan_a        = u.chan_a.conflict;
			s.boundary_violation_chan_a = u.chan_a.boundary;
			s.content_error_chan_a      = u.chan_a.content;
			s.syntax_error_chan_a       = u.chan_a.syntax;
			s.good_frame_chan_a         = u.chan_a.good_frame;
		end
		else
		begin
			// sticky transmit flag survives: only a host clear or a rewrite may drop it
			s = slot_status_t'(32'(s) & ~(CHAN_A_MASK & ~STICKY_MASK));
		end
		if (u.assign_b)
		begin
			s.tx_done_chan_b            = old.tx_done_chan_b | u.chan_b.tx_done;
			s.idle_slot_chan_b          = u.chan_b.idle;
			s.tx_conflict_chan_b        = u.chan_b.conflict;
			s.boundary_violation_chan_b = u.chan_b.boundary;
			s.content_error_chan_b      = u.chan_b.content;
			s.syntax_error_chan_b       = u.chan_b.syntax;
			s.good_frame_chan_b         = u.chan_b.good_frame;
		end
		else
		begin
			s = slot_status_t'(32'(s) & ~(CHAN_B_MASK & ~STICKY_MASK));
		end
		// null frames overwrite nothing outside the receive FIFO
		s.unread_overwritten = old.unread_overwritten
			| (u.stored & u.unread & (u.rx_nonnull | u.fifo_member));
		s.zero_hi  = 2'h0;
		s.zero_mid = 2'h0;
		s.zero_13  = 1'b0;
		return s;
	endfunction

	// result waits for the end of the slot after the assigned one
	assign apply       = state_reg.pend_valid & slot_end_in;
	assign applied     = merge(state_reg.stat[state_reg.pend.buf_idx], state_reg.pend);
	assign host_clear  = reg_wr_in & (reg_addr_in == OFS_STATUS);
	assign status_read = reg_rd_in & (reg_addr_in == OFS_STATUS);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BUF; gi++)
		begin : g_entry
			logic         hit_upd;
			logic         hit_rw;
			logic         hit_sel;
			slot_status_t base;
			assign hit_upd = apply & (state_reg.pend.buf_idx == BUF_W'(gi));
			assign hit_rw  = rewrite_in & (rewrite_buf_in == BUF_W'(gi));
			assign hit_sel = state_reg.sel == BUF_W'(gi);
			always_comb
			begin
				base = state_reg.stat[gi];
				if (hit_rw)
				begin
					base = slot_status_t'(STATUS_RESET);
				end
				if (host_clear & hit_sel)
				begin
					base = slot_status_t'(32'(base) & ~(reg_wdata_in & STICKY_MASK));
				end
			end
			// an update in the same cycle lands on top of any clear
			assign stat_n[gi] = hit_upd ? merge(base, state_reg.pend) : base;
			assign chg_n[gi]  = (hit_upd & ((32'(applied) ^ 32'(state_reg.stat[gi])) & CHANGE_MASK) != 32'h0)
				| (state_reg.changed[gi] & ~(status_read & hit_sel));
		end
	endgenerate

	always_comb
	begin
		state_next         = state_reg;
		state_next.stat    = stat_n;
		state_next.changed = chg_n;
		if (reg_wr_in & (reg_addr_in == OFS_SELECT))
		begin
			state_next.sel = reg_wdata_in[BUF_W-1:0];
		end
		// a fresh request replaces a waiting one unless a slot end applies it now
		if (upd_valid_in)
		begin
			state_next.pend       = upd_in;
			state_next.pend_valid = 1'b1;
		end
		else if (apply)
		begin
			state_next.pend_valid = 1'b0;
		end
		state_next.rdata = 32'h0;
		if (reg_rd_in)
		begin
			if (reg_addr_in == OFS_SELECT)
			begin
				state_next.rdata = {25'h0, state_reg.sel};
			end
			else if (reg_addr_in == OFS_STATUS)
			begin
				state_next.rdata = 32'(state_reg.stat[state_reg.sel]);
			end
			else if ((reg_addr_in >= OFS_SUMMARY1) && (reg_addr_in <= OFS_SUMMARY4)
				&& (reg_addr_in[1:0] == 2'h0))
			begin
				state_next.rdata = state_reg.changed[32*((reg_addr_in - OFS_SUMMARY1) >> 2) +: 32];
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_out   = state_reg.rdata;
	assign any_changed_out = |state_reg.changed;

	// checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	logic [BUF_W-1:0] pbuf;
	assign pbuf = state_reg.pend.buf_idx;
	update_t          pu;
	logic             pend_got;
	logic             pend_got_a;
	assign pu         = state_reg.pend;
	assign pend_got_a = pu.assign_a & pu.chan_a.good_frame;
	assign pend_got   = pend_got_a | (pu.assign_b & pu.chan_b.good_frame);

	a_apply_cycle_count: assert property (
		apply |=> state_reg.stat[$past(pbuf)].captured_cycle_count == $past(state_reg.pend.cycle_count))
		else $error("cycle count not captured at slot end");

	a_wait_slot_end: assert property (
		(state_reg.pend_valid & !slot_end_in & !upd_valid_in) |=> state_reg.pend_valid
			&& state_reg.pend == $past(state_reg.pend))
		else $error("pending status left before slot end");

	a_unassigned_clear: assert property (
		(apply & !state_reg.pend.assign_b)
			|=> (32'(state_reg.stat[$past(pbuf)]) & CHAN_B_MASK & ~STICKY_MASK) == 32'h0)
		else $error("unassigned channel flags not cleared");

	a_both_channels: assert property (
		(apply & state_reg.pend.assign_a & state_reg.pend.assign_b)
			|=> state_reg.stat[$past(pbuf)].good_frame_chan_a == $past(state_reg.pend.chan_a.good_frame)
			&& state_reg.stat[$past(pbuf)].good_frame_chan_b == $past(state_reg.pend.chan_b.good_frame))
		else $error("channels not updated together");

	a_rewrite_clears: assert property (
		(rewrite_in & !(apply & (pbuf == rewrite_buf_in))) |=> state_reg.stat[$past(rewrite_buf_in)] == '0)
		else $error("rewrite left status flags");

	a_summary_set: assert property (
		(apply & (((32'(applied) ^ 32'(state_reg.stat[pbuf])) & CHANGE_MASK) != 32'h0))
			|=> state_reg.changed[$past(pbuf)])
		else $error("summary bit not set on change");

	a_sticky_held: assert property (
		(!rewrite_in & !host_clear & state_reg.stat[state_reg.sel].tx_done_chan_a)
			|=> state_reg.stat[$past(state_reg.sel)].tx_done_chan_a)
		else $error("sticky transmit flag dropped by hardware");

	a_null_no_loss: assert property (
		(apply & !state_reg.pend.rx_nonnull & !state_reg.pend.fifo_member & !rewrite_in
			& !state_reg.stat[pbuf].unread_overwritten)
			|=> !state_reg.stat[$past(pbuf)].unread_overwritten)
		else $error("null frame marked a message lost");

	a_channel_a_flag: assert property (
		(apply & state_reg.pend.assign_a & state_reg.pend.chan_a.good_frame)
			|=> state_reg.stat[$past(pbuf)].rx_channel_indicator)
		else $error("channel indicator wrong for channel A");

	a_status_read: assert property (
		(status_read & !host_clear) |=> reg_rdata_out == 32'($past(state_reg.stat[state_reg.sel])))
		else $error("status read data wrong");

	a_reserved_copy: assert property (
		(apply & pend_got)
			|=> state_reg.stat[$past(pbuf)].rx_reserved_bit == $past(pu.rx_reserved))
		else $error("received reserved bit not captured");

	a_preamble_copy: assert property (
		(apply & pend_got)
			|=> state_reg.stat[$past(pbuf)].rx_preamble_indicator == $past(pu.rx_preamble))
		else $error("preamble indicator not captured");

	a_nonnull_copy: assert property (
		(apply & pend_got)
			|=> state_reg.stat[$past(pbuf)].rx_nonnull_indicator == $past(pu.rx_nonnull))
		else $error("null frame indicator not captured");

	a_sync_copy: assert property (
		(apply & pend_got)
			|=> state_reg.stat[$past(pbuf)].rx_sync_indicator == $past(pu.rx_sync))
		else $error("sync indicator not captured");

	a_startup_copy: assert property (
		(apply & pend_got)
			|=> state_reg.stat[$past(pbuf)].rx_startup_indicator == $past(pu.rx_startup))
		else $error("startup indicator not captured");

	a_channel_b_flag: assert property (
		(apply & pend_got & !pend_got_a)
			|=> !state_reg.stat[$past(pbuf)].rx_channel_indicator)
		else $error("channel indicator wrong for channel B");

	a_tx_done_a: assert property (
		(apply & pu.assign_a & pu.chan_a.tx_done)
			|=> state_reg.stat[$past(pbuf)].tx_done_chan_a)
		else $error("transmit flag A not set");

	a_tx_done_b: assert property (
		(apply & pu.assign_b & pu.chan_b.tx_done)
			|=> state_reg.stat[$past(pbuf)].tx_done_chan_b)
		else $error("transmit flag B not set");

	a_lost_set: assert property (
		(apply & pu.stored & pu.unread & pu.rx_nonnull)
			|=> state_reg.stat[$past(pbuf)].unread_overwritten)
		else $error("overwritten unread message not flagged");

	a_fifo_null_loss: assert property (
		(apply & pu.stored & pu.unread & pu.fifo_member)
			|=> state_reg.stat[$past(pbuf)].unread_overwritten)
		else $error("receive queue loss not flagged");

	a_idle_slot_a: assert property (
		(apply & pu.assign_a)
			|=> state_reg.stat[$past(pbuf)].idle_slot_chan_a == $past(pu.chan_a.idle))
		else $error("empty slot flag A wrong");

	a_idle_slot_b: assert property (
		(apply & pu.assign_b)
			|=> state_reg.stat[$past(pbuf)].idle_slot_chan_b == $past(pu.chan_b.idle))
		else $error("empty slot flag B wrong");

	a_conflict_a: assert property (
		(apply & pu.assign_a)
			|=> state_reg.stat[$past(pbuf)].tx_conflict_chan_a == $past(pu.chan_a.conflict))
		else $error("collision flag A wrong");

	a_conflict_b: assert property (
		(apply & pu.assign_b)
			|=> state_reg.stat[$past(pbuf)].tx_conflict_chan_b == $past(pu.chan_b.conflict))
		else $error("collision flag B wrong");

	a_boundary_b: assert property (
		(apply & pu.assign_b)
			|=> state_reg.stat[$past(pbuf)].boundary_violation_chan_b == $past(pu.chan_b.boundary))
		else $error("boundary violation flag B wrong");

	a_content_b: assert property (
		(apply & pu.assign_b)
			|=> state_reg.stat[$past(pbuf)].content_error_chan_b == $past(pu.chan_b.content))
		else $error("content error flag B wrong");

	a_syntax_b: assert property (
		(apply & pu.assign_b)
			|=> state_reg.stat[$past(pbuf)].syntax_error_chan_b == $past(pu.chan_b.syntax))
		else $error("syntax error flag B wrong");

	a_unassigned_a_clear: assert property (
		(apply & !pu.assign_a)
			|=> (32'(state_reg.stat[$past(pbuf)]) & CHAN_A_MASK & ~STICKY_MASK) == 32'h0)
		else $error("unassigned channel A flags not cleared");

	a_sticky_b_held: assert property (
		(!rewrite_in & !host_clear & state_reg.stat[state_reg.sel].tx_done_chan_b)
			|=> state_reg.stat[$past(state_reg.sel)].tx_done_chan_b)
		else $error("sticky transmit flag B dropped by hardware");

	a_lost_held: assert property (
		(!rewrite_in & !host_clear & state_reg.stat[state_reg.sel].unread_overwritten)
			|=> state_reg.stat[$past(state_reg.sel)].unread_overwritten)
		else $error("message lost flag dropped by hardware");

endmodule // buffer_slot_status

/* rtl/slot_status_pkg.sv */
/*
 * Shared types and constants of the buffer slot status bank: register
 * offsets, status word layout, flag masks and the update record.
 * Assumes one clock domain shared with the message handler.
 */
package slot_status_pkg;

	localparam int          NUM_BUF      = 128;
	localparam int          BUF_W        = 7;
	localparam int          SUMMARY_REGS = 4;

	// register offsets, byte addresses on the plain register port
	localparam logic [7:0]  OFS_SELECT   = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_SUMMARY1 = 8'h08;
	localparam logic [7:0]  OFS_SUMMARY4 = 8'h14;

	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] STICKY_MASK  = 32'h0000_D000;
	localparam logic [31:0] CHANGE_MASK  = 32'h0000_DFFF;
	localparam logic [31:0] CHAN_A_MASK  = 32'h0000_4555;
	localparam logic [31:0] CHAN_B_MASK  = 32'h0000_8AAA;

	typedef struct packed {
		logic [1:0] zero_hi;
		logic       rx_reserved_bit;
		logic       rx_preamble_indicator;
		logic       rx_nonnull_indicator;
		logic       rx_sync_indicator;
		logic       rx_startup_indicator;
		logic       rx_channel_indicator;
		logic [1:0] zero_mid;
		logic [5:0] captured_cycle_count;
		logic       tx_done_chan_b;
		logic       tx_done_chan_a;
		logic       zero_13;
		logic       unread_overwritten;
		logic       idle_slot_chan_b;
		logic       idle_slot_chan_a;
		logic       tx_conflict_chan_b;
		logic       tx_conflict_chan_a;
		logic       boundary_violation_chan_b;
		logic       boundary_violation_chan_a;
		logic       content_error_chan_b;
		logic       content_error_chan_a;
		logic       syntax_error_chan_b;
		logic       syntax_error_chan_a;
		logic       good_frame_chan_b;
		logic       good_frame_chan_a;
	} slot_status_t;

	// slot outcome seen on one channel
	typedef struct packed {
		logic tx_done;
		logic conflict;
		logic idle;
		logic boundary;
		logic content;
		logic syntax;
		logic good_frame;
	} chan_result_t;

	// one status update handed over by the message handler
	typedef struct packed {
		logic [BUF_W-1:0] buf_idx;
		logic             assign_a;
		logic             assign_b;
		logic             fifo_member;
		logic             stored;
		logic             unread;
		logic             rx_reserved;
		logic             rx_preamble;
		logic             rx_nonnull;
		logic             rx_sync;
		logic             rx_startup;
		logic [5:0]       cycle_count;
		chan_result_t     chan_a;
		chan_result_t     chan_b;
	} update_t;

endpackage

/* tb/host_model.sv */
/*
 * Host model: master of the status bank's register port.
 * Assumes read data stand only in the cycle after the strobe.
 */
`timescale 1ns/10ps
module host_model
	import slot_status_pkg::*;
(
	// clock
	input  wire logic        mclk_in,
	// register port
	output logic      [7:0]  reg_addr_out,
	output logic      [31:0] reg_wdata_out,
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	input  wire logic [31:0] reg_rdata_in
);
	initial
	begin
		reg_addr_out  = 8'h00;
		reg_wdata_out = 32'h0000_0000;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_out  <= a;
		reg_wdata_out <= d;
		reg_wr_out    <= 1'b1;
		@(posedge mclk_in);
		reg_wr_out    <= 1'b0;
	endtask
	// data taken mid-cycle, clear of the edge that updates them
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_out <= a;
		reg_rd_out   <= 1'b1;
		@(posedge mclk_in);
		reg_rd_out   <= 1'b0;
		@(negedge mclk_in);
		d = reg_rdata_in;
	endtask
	// sticky flags are ours to clear; the bank drops them only on a rewrite
	task clear_sticky;
		wr(OFS_STATUS, STICKY_MASK);
	endtask
endmodule // host_model

/* tb/tb.sv */
/*
 * Self-checking bench of the slot status bank.
 * Assumes host_model on the register port; the bench plays the handler.
 */
`timescale 1ns/10ps
module tb import slot_status_pkg::*;;
	logic             mclk_in;
	logic             rst_b_in;
	logic             upd_valid_in;
	logic             slot_end_in;
	logic             rewrite_in;
	logic [BUF_W-1:0] rewrite_buf_in;
	update_t          upd_in;
	logic             any_changed_out;
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic             wr;
	logic             rd;
	logic [31:0]      rdata;
	logic [31:0]      d;
	int               fails;
	int               n_compared;

	buffer_slot_status i_buffer_slot_status (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .upd_valid_in(upd_valid_in), .upd_in(upd_in),
		.slot_end_in(slot_end_in), .rewrite_in(rewrite_in),
		.rewrite_buf_in(rewrite_buf_in), .any_changed_out(any_changed_out));
	host_model i_host_model (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));

	initial
	begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge mclk_in);
		fails++;
		end_of_test;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task rs(input logic [7:0] a, input logic [31:0] e, input string n);
		i_host_model.rd(a, d);
		chk(n, d, e);
	endtask
	// result stays pending until a later slot end
	task ap(input update_t u, input logic [31:0] old);
		i_host_model.wr(OFS_SELECT, {25'h0, u.buf_idx});
		@(posedge mclk_in);
		upd_in       <= u;
		upd_valid_in <= 1'b1;
		@(posedge mclk_in);
		upd_valid_in <= 1'b0;
		rs(OFS_STATUS, old, "pending");
		@(posedge mclk_in);
		slot_end_in <= 1'b1;
		@(posedge mclk_in);
		slot_end_in <= 1'b0;
	endtask
	task s_reset;
		rs(OFS_SELECT, 32'h0000_0000, "select");
		rs(OFS_STATUS, STATUS_RESET, "status");
		rs(OFS_SUMMARY4, 32'h0000_0000, "summary4");
		rs(8'hFC, 32'h0000_0000, "unmapped");
		chk("changed", {31'h0, any_changed_out}, 32'h0000_0000);
	endtask
	task s_both;
		ap(update_t'({7'h05, 5'h1B, 5'h1D, 6'h2A, 7'h7F, 7'h54}), 32'h0000_0000);
		rs(OFS_SUMMARY1, 32'h0000_0020, "summary1");
		chk("changed", {31'h0, any_changed_out}, 32'h0000_0001);
		rs(OFS_STATUS, 32'h3B2A_DD75, "both");
		rs(OFS_SUMMARY1, 32'h0000_0000, "summary1 read");
		i_host_model.clear_sticky;
		rs(OFS_STATUS, 32'h3B2A_0D75, "cleared");
	endtask
	task s_single;
		ap(update_t'({7'h05, 5'h13, 5'h00, 6'h01, 7'h01, 7'h3F}), 32'h3B2A_0D75);
		rs(OFS_STATUS, 32'h0101_0001, "single");
	endtask
	task s_fifo;
		ap(update_t'({7'h06, 5'h0F, 5'h00, 6'h3F, 7'h00, 7'h01}), 32'h0000_0000);
		rs(OFS_SUMMARY1, 32'h0000_0040, "summary1");
		rs(OFS_STATUS, 32'h003F_1002, "fifo null");
		ap(update_t'({7'h06, 5'h08, 5'h00, 6'h02, 7'h00, 7'h00}), 32'h003F_1002);
		rs(OFS_STATUS, 32'h0002_1000, "lost kept");
	endtask
	task s_rewrite;
		@(posedge mclk_in);
		rewrite_buf_in <= 7'h06;
		rewrite_in     <= 1'b1;
		@(posedge mclk_in);
		rewrite_in     <= 1'b0;
		rs(OFS_STATUS, 32'h0000_0000, "rewrite");
	endtask
	task s_high;
		ap(update_t'({7'h7F, 5'h10, 5'h00, 6'h15, 7'h10, 7'h3F}), 32'h0000_0000);
		rs(OFS_SUMMARY4, 32'h8000_0000, "summary4");
		rs(OFS_STATUS, 32'h0015_0400, "idle a");
	endtask
	// every channel B flag raised, then channel A alone keeps the B transmit flag
	task s_chan_b;
		ap(update_t'({7'h7F, 5'h0A, 5'h06, 6'h30, 7'h7F, 7'h7F}), 32'h0015_0400);
		rs(OFS_STATUS, 32'h0C30_8AAA, "chan b");
		ap(update_t'({7'h7F, 5'h10, 5'h00, 6'h31, 7'h00, 7'h00}), 32'h0C30_8AAA);
		rs(OFS_STATUS, 32'h0C31_8000, "sticky b kept");
	endtask
	initial
	begin
		fails          = 0;
		n_compared     = 0;
		rst_b_in       = 1'b0;
		upd_valid_in   = 1'b0;
		slot_end_in    = 1'b0;
		rewrite_in     = 1'b0;
		rewrite_buf_in = 7'h00;
		upd_in         = '0;
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		s_reset;
		s_both;
		s_single;
		s_fifo;
		s_rewrite;
		s_high;
		s_chan_b;
		end_of_test;
	end
endmodule // tb
